/* File: src/tlr_regs.sv */
// tlb reload, space tag and access protection register set
`timescale 1ns/1ps
`include "tlr_params.svh"
module tlr_regs
  import tlr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  // special register access
  input wire logic SPR_WE_I,
  input wire logic SPR_RE_I,
  input wire logic [9:0] SPR_NUM_I,
  input wire logic [31:0] SPR_WDATA_I,
  output logic [31:0] SPR_RDATA_O,
  // miss and update events
  input wire logic IMISS_I,
  input wire logic [31:0] IMISS_EA_I,
  input wire logic DATA_TLB_UPDATE_I,
  input wire logic [31:0] DATA_EPN_I,
  input wire logic [4:0] TLB_LOAD_POINTER_I,
  input wire logic PAGE_PROT_MODE_I,
  // entry lookup
  input wire logic LK_REQ_I,
  input wire logic LK_PRIV_I,
  input wire logic LK_EXT_I,
  input wire logic [3:0] LK_GROUP_I,
  input wire logic [7:0] LK_PERM_I,
  input wire logic [1:0] LK_SUBPAGE_I,
  input wire logic [3:0] LK_SPV_I,
  input wire logic LK_GLOBAL_I,
  input wire logic [3:0] LK_TAG_I,
  output logic LK_HIT_O,
  output logic LK_EXEC_O,
  // entry commit
  output logic TLB_WR_O,
  output logic [4:0] TLB_WR_IDX_O,
  output logic [31:0] TLB_WR_EPN_O,
  output logic [31:0] TLB_WR_TWC_O,
  output logic [31:0] TLB_WR_RPN_O,
  output logic TLB_WR_PAGE16K_O
);

  // ==========================================================
  // state
  tlr_state_s st;
  tlr_state_s next_st;
  logic [4:0] ptr;
  logic [1:0] grp_code;
  logic dec_hit;
  logic dec_exec;
  logic [9:0] l1_index;

  assign ptr = st.dctrl[`TLR_DC_PTR_HI:`TLR_DC_PTR_LO];
  assign grp_code = st.ap[31 - 2 * LK_GROUP_I -: 2];
  assign l1_index = st.dctrl[`TLR_DC_WALK_ASSIST_MODE] ? DATA_EPN_I[31:22] : DATA_EPN_I[29:20];

  // ==========================================================
  // protection decode
  tlr_prot_decode u_dec (
    .domain_mode_i(st.dctrl[`TLR_DC_GPM]),
    .prot_1k_i(PAGE_PROT_MODE_I),
    .ext_enc_i(LK_EXT_I),
    .priv_cmp_i(st.dctrl[`TLR_DC_PRIV_COMPARE_MODE]),
    .priv_i(LK_PRIV_I),
    .group_code_i(grp_code),
    .perm_i(LK_PERM_I),
    .subpage_i(LK_SUBPAGE_I),
    .spv_i(LK_SPV_I),
    .global_i(LK_GLOBAL_I),
    .entry_tag_i(LK_TAG_I),
    .cur_tag_i(st.current_space_tag),
    .hit_o(dec_hit),
    .exec_o(dec_exec)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.wr = 1'b0;
    next_st.lk_hit = LK_REQ_I & dec_hit;
    next_st.lk_exec = LK_REQ_I & dec_exec;
    if (SPR_WE_I) begin
      case (SPR_NUM_I)
        `TLR_SPR_DCTRL: next_st.dctrl = SPR_WDATA_I & `TLR_DCTRL_MASK;
        `TLR_SPR_AP: next_st.ap = SPR_WDATA_I;
        `TLR_SPR_CURRENT_SPACE_TAG: next_st.current_space_tag = SPR_WDATA_I[3:0];
        `TLR_SPR_TWB: next_st.twb_base = SPR_WDATA_I[31:12];
        `TLR_SPR_TW: next_st.tw = SPR_WDATA_I;
        `TLR_SPR_EPN: next_st.effective_page = SPR_WDATA_I & `TLR_EPN_MASK;
        `TLR_SPR_TWC: next_st.twc = SPR_WDATA_I & `TLR_TWC_MASK;
        `TLR_SPR_RPN: begin
          next_st.real_page = SPR_WDATA_I;
          // staged words and the new real page go out together
          next_st.wr = 1'b1;
          next_st.wr_idx = TLB_LOAD_POINTER_I;
          next_st.wr_epn = st.effective_page;
          next_st.wr_twc = st.twc;
          next_st.wr_rpn = SPR_WDATA_I;
          next_st.wr_16k = SPR_WDATA_I[`TLR_RPN_LPS] & ~PAGE_PROT_MODE_I;
        end
        default: next_st.wr = 1'b0;
      endcase
    end
    // hardware miss wins over a software write in the same cycle
    if (IMISS_I) begin
      next_st.effective_page[31:12] = IMISS_EA_I[31:12];
      next_st.effective_page[`TLR_EPN_EV] = 1'b1;
      next_st.twc = `TLR_TWC_MISS;
    end
    if (DATA_TLB_UPDATE_I) begin
      if (ptr == 5'h00) begin
        next_st.dctrl[`TLR_DC_PTR_HI:`TLR_DC_PTR_LO] =
          st.dctrl[`TLR_DC_RSV] ? `TLR_WRAP6 : `TLR_WRAP8;
      end else begin
        next_st.dctrl[`TLR_DC_PTR_HI:`TLR_DC_PTR_LO] = ptr - 5'h01;
      end
    end
    next_st.rdata = 32'h00000000;
    if (SPR_RE_I) begin
      case (SPR_NUM_I)
        `TLR_SPR_DCTRL: next_st.rdata = st.dctrl;
        `TLR_SPR_AP: next_st.rdata = st.ap;
        `TLR_SPR_CURRENT_SPACE_TAG: next_st.rdata = {28'h0000000, st.current_space_tag};
        `TLR_SPR_TWB: next_st.rdata = {st.twb_base, l1_index, 2'b00};
        `TLR_SPR_TW: next_st.rdata = st.tw;
        `TLR_SPR_EPN: next_st.rdata = st.effective_page;
        `TLR_SPR_TWC: next_st.rdata = st.twc;
        `TLR_SPR_RPN: next_st.rdata = st.real_page;
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // registers
  // undefined-reset registers are left unforced
  always_ff @(posedge CLK_I) begin
    st <= next_st;
    if (RST_I) begin
      st.dctrl <= `TLR_DCTRL_RST;
      st.rdata <= 32'h00000000;
      st.lk_hit <= 1'b0;
      st.lk_exec <= 1'b0;
      st.wr <= 1'b0;
      st.wr_idx <= 5'h00;
      st.wr_epn <= 32'h00000000;
      st.wr_twc <= 32'h00000000;
      st.wr_rpn <= 32'h00000000;
      st.wr_16k <= 1'b0;
    end
  end

  assign SPR_RDATA_O = st.rdata;
  assign LK_HIT_O = st.lk_hit;
  assign LK_EXEC_O = st.lk_exec;
  assign TLB_WR_O = st.wr;
  assign TLB_WR_IDX_O = st.wr_idx;
  assign TLB_WR_EPN_O = st.wr_epn;
  assign TLB_WR_TWC_O = st.wr_twc;
  assign TLB_WR_RPN_O = st.wr_rpn;
  assign TLB_WR_PAGE16K_O = st.wr_16k;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_upd_nz;
    DATA_TLB_UPDATE_I && ptr != 5'h00;
  endsequence

  property p_ptr_dec;
    s_upd_nz |=> ptr == $past(ptr) - 5'h01;
  endproperty
  a_ptr_dec: assert property (p_ptr_dec) else $error("data pointer not decremented");

  property p_dctrl_rsv;
    SPR_RE_I && SPR_NUM_I == `TLR_SPR_DCTRL
      |=> (SPR_RDATA_O & ~`TLR_DCTRL_MASK) == 32'h00000000;
  endproperty
  a_dctrl_rsv: assert property (p_dctrl_rsv) else $error("reserved bits read nonzero");

  property p_twb_read;
    SPR_RE_I && SPR_NUM_I == `TLR_SPR_TWB
      |=> SPR_RDATA_O[1:0] == 2'b00 && SPR_RDATA_O[11:2] == $past(l1_index);
  endproperty
  a_twb_read: assert property (p_twb_read) else $error("walk base read wrong");

  sequence s_tw_wr;
    SPR_WE_I && SPR_NUM_I == `TLR_SPR_TW && !SPR_RE_I;
  endsequence
  sequence s_tw_rd;
    SPR_RE_I && SPR_NUM_I == `TLR_SPR_TW && !SPR_WE_I;
  endsequence

  property p_scratch;
    s_tw_wr ##1 s_tw_rd |=> SPR_RDATA_O == $past(SPR_WDATA_I, 2);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch lost its value");

  property p_miss_stage;
    IMISS_I |=> st.effective_page[31:12] == $past(IMISS_EA_I[31:12]) && st.effective_page[`TLR_EPN_EV]
      && st.twc == `TLR_TWC_MISS;
  endproperty
  a_miss_stage: assert property (p_miss_stage) else $error("miss defaults wrong");

  sequence s_rpn_wr;
    SPR_WE_I && SPR_NUM_I == `TLR_SPR_RPN;
  endsequence

  property p_commit;
    s_rpn_wr |=> TLB_WR_O && TLB_WR_RPN_O == $past(SPR_WDATA_I)
      && TLB_WR_EPN_O == $past(st.effective_page) && TLB_WR_IDX_O == $past(TLB_LOAD_POINTER_I);
  endproperty
  a_commit: assert property (p_commit) else $error("entry commit wrong");

  property p_no_commit;
    !(SPR_WE_I && SPR_NUM_I == `TLR_SPR_RPN) |=> !TLB_WR_O;
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("spurious commit");

  property p_tag_miss;
    LK_REQ_I && !LK_GLOBAL_I && LK_TAG_I != st.current_space_tag |=> !LK_HIT_O;
  endproperty
  a_tag_miss: assert property (p_tag_miss) else $error("tag mismatch hit");

  property p_manager;
    LK_REQ_I && st.dctrl[`TLR_DC_GPM] && grp_code == 2'b11 |=> LK_EXEC_O;
  endproperty
  a_manager: assert property (p_manager) else $error("manager access refused");

  property p_deny;
    LK_REQ_I && st.dctrl[`TLR_DC_GPM] && grp_code == 2'b00 |=> !LK_EXEC_O;
  endproperty
  a_deny: assert property (p_deny) else $error("denied group allowed");

  property p_ptr_wrap;
    DATA_TLB_UPDATE_I && ptr == 5'h00
      |=> ptr == ($past(st.dctrl[`TLR_DC_RSV]) ? `TLR_WRAP6 : `TLR_WRAP8);
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("data pointer wrap wrong");

  property p_current_space_tag_read;
    SPR_RE_I && SPR_NUM_I == `TLR_SPR_CURRENT_SPACE_TAG |=> SPR_RDATA_O[31:4] == 28'h0000000;
  endproperty
  a_current_space_tag_read: assert property (p_current_space_tag_read) else $error("space tag upper bits set");

  // read data must not linger, the core may sample the bus every cycle
  property p_rd_idle;
    !SPR_RE_I |=> SPR_RDATA_O == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

  property p_miss_group;
    IMISS_I |=> st.twc[8:5] == 4'h0;
  endproperty
  a_miss_group: assert property (p_miss_group) else $error("miss group not zero");

  property p_miss_ev;
    IMISS_I |=> st.effective_page[`TLR_EPN_EV];
  endproperty
  a_miss_ev: assert property (p_miss_ev) else $error("miss left entry invalid");

  property p_miss_guard;
    IMISS_I |=> !st.twc[4];
  endproperty
  a_miss_guard: assert property (p_miss_guard) else $error("miss left guarded set");

  property p_miss_size;
    IMISS_I |=> st.twc[3:2] == 2'h0;
  endproperty
  a_miss_size: assert property (p_miss_size) else $error("miss page size not small");

  property p_miss_valid;
    IMISS_I |=> st.twc[0];
  endproperty
  a_miss_valid: assert property (p_miss_valid) else $error("miss control not valid");

  property p_commit_ctrl;
    s_rpn_wr |=> TLB_WR_TWC_O == $past(st.twc);
  endproperty
  a_commit_ctrl: assert property (p_commit_ctrl) else $error("commit control wrong");

  property p_commit_16k;
    s_rpn_wr
      |=> TLB_WR_PAGE16K_O == ($past(SPR_WDATA_I[`TLR_RPN_LPS]) && !$past(PAGE_PROT_MODE_I));
  endproperty
  a_commit_16k: assert property (p_commit_16k) else $error("large page select wrong");

  property p_lk_idle;
    !LK_REQ_I |=> !LK_HIT_O && !LK_EXEC_O;
  endproperty
  a_lk_idle: assert property (p_lk_idle) else $error("lookup result without request");

  // lookup whose subpage is valid with privilege compare off
  sequence s_lk_tag_ok;
    LK_REQ_I && !st.dctrl[`TLR_DC_PRIV_COMPARE_MODE] && LK_SPV_I[3 - LK_SUBPAGE_I];
  endsequence

  property p_tag_hit;
    s_lk_tag_ok ##0 (LK_TAG_I == st.current_space_tag) |=> LK_HIT_O;
  endproperty
  a_tag_hit: assert property (p_tag_hit) else $error("equal tags missed");

  property p_global_hit;
    s_lk_tag_ok ##0 LK_GLOBAL_I |=> LK_HIT_O;
  endproperty
  a_global_hit: assert property (p_global_hit) else $error("global entry missed");

  property p_sub_invalid;
    LK_REQ_I && !st.dctrl[`TLR_DC_PRIV_COMPARE_MODE] && !LK_SPV_I[3 - LK_SUBPAGE_I] |=> !LK_HIT_O;
  endproperty
  a_sub_invalid: assert property (p_sub_invalid) else $error("invalid subpage hit");

  // privileged lookup in a group that defers to the page bits
  sequence s_lk_page;
    LK_REQ_I && grp_code == 2'b01 && LK_PRIV_I;
  endsequence

  property p_ext_none;
    LK_REQ_I && !st.dctrl[`TLR_DC_GPM] && !PAGE_PROT_MODE_I && LK_EXT_I
      && LK_PERM_I[7:6] == 2'b00 |=> !LK_EXEC_O;
  endproperty
  a_ext_none: assert property (p_ext_none) else $error("extended no access allowed");

  property p_1k_none;
    s_lk_page ##0 (PAGE_PROT_MODE_I && LK_PERM_I[7 - 2 * LK_SUBPAGE_I -: 2] == 2'b00)
      |=> !LK_EXEC_O;
  endproperty
  a_1k_none: assert property (p_1k_none) else $error("1k no access allowed");

  property p_subpage_sel;
    s_lk_page ##0 (PAGE_PROT_MODE_I && LK_SUBPAGE_I == 2'h2)
      |=> LK_EXEC_O == ($past(LK_PERM_I[3:2]) != 2'b00);
  endproperty
  a_subpage_sel: assert property (p_subpage_sel) else $error("third subpage field unused");

endmodule : tlr_regs

/* File: include/tlr_params.svh */
// register numbers, field layouts and reset values of the tlb reload registers
`ifndef TLR_PARAMS_SVH
`define TLR_PARAMS_SVH

// special register numbers seen by move-to / move-from
`define TLR_SPR_DCTRL 10'h318
`define TLR_SPR_AP 10'h31A
`define TLR_SPR_CURRENT_SPACE_TAG 10'h319
`define TLR_SPR_TWB 10'h31C
`define TLR_SPR_TW 10'h3DF
`define TLR_SPR_EPN 10'h313
`define TLR_SPR_TWC 10'h315
`define TLR_SPR_RPN 10'h316

// data_xlate_ctrl layout, big-endian bit n sits at [31-n]
`define TLR_DCTRL_RST 32'h00000000
`define TLR_DCTRL_MASK 32'hFE001F00
`define TLR_DC_GPM 31
`define TLR_DC_PPM 30
`define TLR_DC_RSV 27
`define TLR_DC_WALK_ASSIST_MODE 26
`define TLR_DC_PRIV_COMPARE_MODE 25
`define TLR_DC_PTR_HI 12
`define TLR_DC_PTR_LO 8
`define TLR_WRAP8 5'h07
`define TLR_WRAP6 5'h05

// other masks and fields
`define TLR_CURRENT_SPACE_TAG_MASK 32'h0000000F
`define TLR_TWB_MASK 32'hFFFFF000
`define TLR_EPN_MASK 32'hFFFFF20F
`define TLR_EPN_EV 9
`define TLR_TWC_MASK 32'h000001FD
`define TLR_TWC_MISS 32'h00000001
`define TLR_RPN_LPS 3

`endif

/* File: include/tlr_pkg.sv */
// types shared by the tlb reload register block
package tlr_pkg;

  typedef struct packed {
    logic [31:0] dctrl;
    logic [31:0] ap;
    logic [3:0] current_space_tag;
    logic [19:0] twb_base;
    logic [31:0] tw;
    logic [31:0] effective_page;
    logic [31:0] twc;
    logic [31:0] real_page;
    logic [31:0] rdata;
    logic lk_hit;
    logic lk_exec;
    logic wr;
    logic [4:0] wr_idx;
    logic [31:0] wr_epn;
    logic [31:0] wr_twc;
    logic [31:0] wr_rpn;
    logic wr_16k;
  } tlr_state_s;

endpackage : tlr_pkg

/* File: src/tlr_prot_decode.sv */
// match and execute-permission decode of one tlb entry lookup
`timescale 1ns/1ps
module tlr_prot_decode
  import tlr_pkg::*;
(
  input wire logic domain_mode_i,
  input wire logic prot_1k_i,
  input wire logic ext_enc_i,
  input wire logic priv_cmp_i,
  input wire logic priv_i,
  input wire logic [1:0] group_code_i,
  input wire logic [7:0] perm_i,
  input wire logic [1:0] subpage_i,
  input wire logic [3:0] spv_i,
  input wire logic global_i,
  input wire logic [3:0] entry_tag_i,
  input wire logic [3:0] cur_tag_i,
  output logic hit_o,
  output logic exec_o
);

  logic eff_priv;
  logic use_pp;
  logic force_ok;
  logic [1:0] code;
  logic pp_priv;
  logic pp_prob;
  logic pp_ok;

  always_comb begin
    eff_priv = priv_i;
    use_pp = 1'b1;
    force_ok = 1'b0;
    if (domain_mode_i) begin
      use_pp = (group_code_i == 2'b01);
      force_ok = (group_code_i == 2'b11);
    end else begin
      case (group_code_i)
        2'b00: eff_priv = 1'b1;
        2'b10: eff_priv = ~priv_i;
        2'b11: eff_priv = 1'b0;
        default: eff_priv = priv_i;
      endcase
    end
    // field 0 covers the first 1K subpage
    code = prot_1k_i ? perm_i[7 - 2 * subpage_i -: 2] : perm_i[7:6];
    pp_priv = 1'b0;
    pp_prob = 1'b0;
    if (prot_1k_i) begin
      pp_priv = (code != 2'b00);
      pp_prob = code[1];
    end else if (ext_enc_i) begin
      // reserved codes grant nothing
      pp_priv = (code == 2'b01);
    end else begin
      pp_priv = 1'b1;
      pp_prob = (code != 2'b00);
    end
    pp_ok = eff_priv ? pp_priv : pp_prob;
    exec_o = force_ok | (use_pp & pp_ok);
    hit_o = global_i | (entry_tag_i == cur_tag_i);
    if (priv_cmp_i) begin
      hit_o = hit_o & (priv_i ? spv_i[3] : spv_i[2]);
    end else begin
      hit_o = hit_o & spv_i[3 - subpage_i];
    end
  end

endmodule : tlr_prot_decode

/* File: bench/tlr_regs_tb_top.sv */
// self-checking bench for the tlb reload and protection register set
`timescale 1ns/1ps
`include "tlr_params.svh"
module tlr_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic we = 1'b0, re = 1'b0, miss = 1'b0, dupd = 1'b0, ppm = 1'b0;
  logic req = 1'b0, lpriv = 1'b0, lext = 1'b0, lglob = 1'b0;
  logic [9:0] num = 10'h000;
  logic [31:0] wd = 32'h0, miss_ea = 32'h0, depn = 32'h0;
  logic [4:0] lptr = 5'h00;
  logic [3:0] lgrp = 4'h0, lspv = 4'h0, ltag = 4'h0;
  logic [7:0] lperm = 8'h00;
  logic [1:0] lsub = 2'h0;
  logic [31:0] rd, w_epn, w_twc, w_rpn;
  logic hit, ex, wr, w16;
  logic [4:0] widx;
  int err_total = 0;
  int checks_done = 0;

  tlr_regs u_dut (.CLK_I(clk), .RST_I(rst), .SPR_WE_I(we), .SPR_RE_I(re), .SPR_NUM_I(num),
    .SPR_WDATA_I(wd), .SPR_RDATA_O(rd), .IMISS_I(miss), .IMISS_EA_I(miss_ea),
    .DATA_TLB_UPDATE_I(dupd), .DATA_EPN_I(depn), .TLB_LOAD_POINTER_I(lptr),
    .PAGE_PROT_MODE_I(ppm), .LK_REQ_I(req), .LK_PRIV_I(lpriv), .LK_EXT_I(lext),
    .LK_GROUP_I(lgrp), .LK_PERM_I(lperm), .LK_SUBPAGE_I(lsub), .LK_SPV_I(lspv),
    .LK_GLOBAL_I(lglob), .LK_TAG_I(ltag), .LK_HIT_O(hit), .LK_EXEC_O(ex), .TLB_WR_O(wr),
    .TLB_WR_IDX_O(widx), .TLB_WR_EPN_O(w_epn), .TLB_WR_TWC_O(w_twc), .TLB_WR_RPN_O(w_rpn),
    .TLB_WR_PAGE16K_O(w16));

  // ==========================================
  // shared tasks
  initial forever #20 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // strobes rise at a falling edge and fall one cycle later, after the taking edge
  task automatic wr_reg(input logic [9:0] n, input logic [31:0] d);
    @(negedge clk); we = 1'b1; num = n; wd = d;
    @(negedge clk); we = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [9:0] n, input logic [31:0] m, input logic [31:0] exp,
                        input string what);
    @(negedge clk); re = 1'b1; num = n;
    @(negedge clk); re = 1'b0;
    chk(what, rd & m, exp);
  endtask : rd_reg

  task automatic pulse(ref logic s);
    @(negedge clk); s = 1'b1;
    @(negedge clk); s = 1'b0;
  endtask : pulse

  // reference decode of execute permission, kept apart from the design's own
  function automatic logic exp_exec(input logic gm, ext, onek, priv, input logic [1:0] g, pp);
    logic p;
    p = priv;
    if (gm) begin
      if (g == 2'b00 || g == 2'b10) return 1'b0;
      if (g == 2'b11) return 1'b1;
    end else begin
      p = (g == 2'b00) ? 1'b1 : (g == 2'b11) ? 1'b0 : (g == 2'b10) ? !priv : priv;
    end
    if (onek) return (pp == 2'b01) ? p : (pp != 2'b00);
    if (ext) return (pp == 2'b01) && p;
    return (pp == 2'b00) ? p : 1'b1;
  endfunction : exp_exec

  task automatic lk(input logic p, e, input logic [3:0] g, input logic [7:0] pm,
                    input logic [1:0] s, input logic [3:0] sv, input logic gl,
                    input logic [3:0] tg, input logic eh, ee);
    @(negedge clk); req = 1'b1; lpriv = p; lext = e; lgrp = g; lperm = pm;
    lsub = s; lspv = sv; lglob = gl; ltag = tg;
    @(negedge clk); req = 1'b0;
    chk("lookup hit", hit, eh);
    if (eh) chk("lookup exec", ex, ee);
  endtask : lk

  // ==========================================
  // scenarios
  task automatic t_scratch;
    rd_reg(`TLR_SPR_DCTRL, 32'hFFFFFFFF, 32'h0, "dctrl after reset");
    @(negedge clk);
    chk("rdata idle", rd, 32'h0);
    wr_reg(`TLR_SPR_TW, 32'hA5A55A5A);
    rd_reg(`TLR_SPR_TW, 32'hFFFFFFFF, 32'hA5A55A5A, "scratch");
    wr_reg(`TLR_SPR_TW, 32'hFFFFFFFF);
    rd_reg(`TLR_SPR_TW, 32'hFFFFFFFF, 32'hFFFFFFFF, "scratch ones");
    rd_reg(10'h000, 32'hFFFFFFFF, 32'h0, "unmapped");
    wr_reg(10'h000, 32'h00000000);
    rd_reg(`TLR_SPR_TW, 32'hFFFFFFFF, 32'hFFFFFFFF, "unmapped write");
    // back-to-back write then read of the scratch word
    @(negedge clk);
    we = 1'b1;
    num = `TLR_SPR_TW;
    wd = 32'h3C3CC3C3;
    @(negedge clk);
    we = 1'b0;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    chk("scratch back to back", rd, 32'h3C3CC3C3);
  endtask : t_scratch

  task automatic t_reserved;
    depn = 32'hABCDE000;
    wr_reg(`TLR_SPR_DCTRL, 32'hFFFFFFFF);
    rd_reg(`TLR_SPR_DCTRL, 32'hFFFFFFFF, `TLR_DCTRL_MASK, "dctrl reserved");
    wr_reg(`TLR_SPR_CURRENT_SPACE_TAG, 32'hFFFFFFFF);
    rd_reg(`TLR_SPR_CURRENT_SPACE_TAG, 32'hFFFFFFFF, 32'h0000000F, "space tag");
    wr_reg(`TLR_SPR_TWB, 32'hFFFFFFFF);
    rd_reg(`TLR_SPR_TWB, 32'hFFFFFFFF, {20'hFFFFF, depn[31:22], 2'b00}, "base 4k");
    wr_reg(`TLR_SPR_DCTRL, 32'h0);
    rd_reg(`TLR_SPR_TWB, 32'hFFFFFFFF, {20'hFFFFF, depn[29:20], 2'b00}, "base 1k");
  endtask : t_reserved

  task automatic t_pointer;
    wr_reg(`TLR_SPR_DCTRL, 32'h00000300);
    repeat (4) pulse(dupd);
    rd_reg(`TLR_SPR_DCTRL, 32'hFFFFFFFF, 32'h00000700, "pointer wrap 8");
    wr_reg(`TLR_SPR_DCTRL, 32'h08000000);
    pulse(dupd);
    rd_reg(`TLR_SPR_DCTRL, 32'hFFFFFFFF, 32'h08000500, "pointer wrap 6");
  endtask : t_pointer

  task automatic t_miss;
    wr_reg(`TLR_SPR_TWC, 32'h000001FD);
    wr_reg(`TLR_SPR_EPN, 32'h0);
    miss_ea = 32'h12345678;
    pulse(miss);
    rd_reg(`TLR_SPR_EPN, 32'hFFFFF200, 32'h12345200, "miss page");
    rd_reg(`TLR_SPR_TWC, 32'hFFFFFFFF, 32'h00000001, "miss control");
  endtask : t_miss

  task automatic t_commit;
    wr_reg(`TLR_SPR_EPN, 32'h5555520A);
    wr_reg(`TLR_SPR_TWC, 32'h000001FD);
    lptr = 5'h0B;
    ppm = 1'b0;
    wr_reg(`TLR_SPR_RPN, 32'h0000F00F);
    chk("commit", wr, 1'b1);
    chk("commit slot", widx, 5'h0B);
    chk("commit page", w_epn, 32'h5555520A);
    chk("commit ctrl", w_twc, 32'h000001FD);
    chk("commit real", w_rpn, 32'h0000F00F);
    chk("commit 16k", w16, 1'b1);
    @(negedge clk);
    chk("commit end", wr, 1'b0);
    ppm = 1'b1;
    wr_reg(`TLR_SPR_RPN, 32'h0000F00F);
    chk("commit 1k res", w16, 1'b0);
  endtask : t_commit

  task automatic t_lookup;
    wr_reg(`TLR_SPR_AP, 32'h1B000000);
    wr_reg(`TLR_SPR_CURRENT_SPACE_TAG, 32'h5);
    for (int gm = 0; gm < 2; gm++) begin
      wr_reg(`TLR_SPR_DCTRL, gm ? 32'h80000000 : 32'h0);
      for (int g = 0; g < 4; g++) begin
        for (int pr = 0; pr < 2; pr++) begin
          for (int pp = 0; pp < 4; pp++) begin
            for (int md = 0; md < 3; md++) begin
              ppm = (md == 0);
              lk(1'(pr), md == 2, 4'(g), {4{2'(pp)}}, 2'h0, 4'hF, 1'b0, 4'h5, 1'b1,
                 exp_exec(1'(gm), md == 2, md == 0, 1'(pr), 2'(g), 2'(pp)));
            end
          end
        end
      end
    end
    ppm = 1'b1;
    lk(1'b1, 1'b0, 4'h1, 8'h0C, 2'h2, 4'hF, 1'b0, 4'h5, 1'b1, 1'b1);
    lk(1'b1, 1'b0, 4'h1, 8'h0C, 2'h1, 4'hF, 1'b0, 4'h5, 1'b1, 1'b0);
    lk(1'b1, 1'b0, 4'h1, 8'hFF, 2'h0, 4'hF, 1'b0, 4'h6, 1'b0, 1'b0);
    lk(1'b1, 1'b0, 4'h1, 8'hFF, 2'h0, 4'hF, 1'b1, 4'h6, 1'b1, 1'b1);
    lk(1'b1, 1'b0, 4'h1, 8'hFF, 2'h1, 4'h4, 1'b0, 4'h5, 1'b1, 1'b1);
    lk(1'b1, 1'b0, 4'h1, 8'hFF, 2'h0, 4'h4, 1'b0, 4'h5, 1'b0, 1'b0);
    wr_reg(`TLR_SPR_DCTRL, 32'h02000000);
    for (int k = 0; k < 6; k++) begin
      lk(1'(k % 2), 1'b0, 4'h1, 8'hFF, 2'h0, (k < 2) ? 4'h8 : (k < 4) ? 4'h4 : 4'hC, 1'b0,
         4'h5, (k > 3) || ((k < 2) == (k % 2 == 1)), 1'b1);
    end
    @(negedge clk);
    chk("hit idle", hit, 1'b0);
  endtask : t_lookup

  // mid-run reset: clears control and outputs, leaves unforced words alone
  task automatic t_reset;
    wr_reg(`TLR_SPR_DCTRL, 32'hFE001F00);
    @(negedge clk);
    we = 1'b1;
    num = `TLR_SPR_RPN;
    rst = 1'b1;
    @(negedge clk);
    we = 1'b0;
    rst = 1'b0;
    chk("commit under reset", wr, 1'b0);
    rd_reg(`TLR_SPR_DCTRL, 32'hFFFFFFFF, 32'h00000000, "dctrl after mid reset");
    rd_reg(`TLR_SPR_TW, 32'hFFFFFFFF, 32'h3C3CC3C3, "scratch over reset");
  endtask : t_reset

  // ==========================================
  // run control
  task automatic final_report;
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_scratch();
    t_reserved();
    t_pointer();
    t_miss();
    t_commit();
    t_lookup();
    t_reset();
    final_report();
  end
endmodule : tlr_regs_tb_top
